// *** rtl/cfm_pkg.sv ***
// Constants and types shared by the configuration message endpoint
package cfm_pkg;

  // Control token values on the interconnect
  localparam logic [7:0]  TOK_WRITE    = 8'hc0; // Write request header
  localparam logic [7:0]  TOK_READ     = 8'hc1; // Read request header
  localparam logic [7:0]  TOK_END      = 8'h01; // Closes every message
  localparam logic [7:0]  TOK_ACK      = 8'h03; // Success reply
  localparam logic [7:0]  TOK_NAK      = 8'h04; // Failure reply

  // Return identifier low byte that asks for no reply to a write
  localparam logic [7:0]  NO_REPLY_TAG = 8'hff;

  // Processor status resource identifier layout
  localparam logic [7:0]  PS_TAG       = 8'h0b; // Low byte of the id
  localparam int          PS_SHIFT     = 8;     // Register number position

  // Last byte index of each multi-byte field (counter runs 0..last)
  localparam logic [1:0]  RID_LAST     = 2'h2;  // 24-bit return id
  localparam logic [1:0]  REG_LAST     = 2'h1;  // 16-bit register number
  localparam logic [1:0]  DATA_LAST    = 2'h3;  // 32-bit data word

  // Register bank shape and reset contents
  localparam int          REG_AW       = 4;
  localparam int          REG_DW       = 32;
  localparam logic [15:0] REG_NUM      = 16'h0010;
  localparam logic [31:0] REG_RST      = 32'h0000_0000;

  // Message engine states
  typedef enum logic [3:0] {
    ST_IDLE, ST_PS, ST_RID, ST_REG, ST_DATA, ST_END, ST_DROP,
    ST_FIN, ST_ACK, ST_RDATA, ST_CLOSE
  } cfm_state_e;

  // Builds a processor status resource id from a register number
  function automatic logic [15:0] cfm_ps_id(input logic [7:0] regn);
    cfm_ps_id = ({8'h00, regn} << PS_SHIFT) | {8'h00, PS_TAG};
  endfunction : cfm_ps_id

endpackage : cfm_pkg

// *** rtl/cfm_regmem.sv ***
// Configuration register bank with registered read data
`timescale 1ns/10ps
module cfm_regmem
(
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       arst_n,
  // Single port access
  input  wire logic                       we,
  input  wire logic [cfm_pkg::REG_AW-1:0] addr,
  input  wire logic [cfm_pkg::REG_DW-1:0] wdata,
  output logic      [cfm_pkg::REG_DW-1:0] rdata
);
  import cfm_pkg::*;

  localparam int NW = 1 << REG_AW; // Word count

  logic [REG_DW-1:0] mem_r [NW]; // Storage words

  // One flop row per word; reset keeps the bank defined at start-up
  for (genvar i = 0; i < NW; i++)
  begin : g_word
    always_ff @(posedge clock or negedge arst_n)
    begin
      if (!arst_n)
        mem_r[i] <= REG_RST;
      else if (we && addr == REG_AW'(i))
        mem_r[i] <= wdata;
    end
  end

  // Read data lags the address by one edge
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      rdata <= REG_RST;
    else
      rdata <= mem_r[addr];
  end

endmodule : cfm_regmem

// *** rtl/cfm_endpoint.sv ***
// Token message endpoint for configuration register access
// How it works
// - Return id low byte ones: no write reply
// - Multi-byte fields travel most significant first
// - Status id is register shl 8 or 0x0B
// - Write reply: 3,1 on success; 4,1 failure
// - Read reply: 3, data word, 1; else 4,1
// - Peripheral read reply holds access-width bytes
`timescale 1ns/10ps
module cfm_endpoint
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Incoming token stream
  input  wire logic        rx_valid,
  input  wire logic        rx_ctrl,
  input  wire logic [7:0]  rx_data,
  output logic             rx_ready,
  // Outgoing reply stream
  output logic             tx_valid,
  output logic             tx_ctrl,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  output logic [23:0]      tx_dest,
  // Access width of read replies
  input  wire logic        narrow_access,
  // Processor status port
  input  wire logic        ps_valid,
  input  wire logic        ps_write,
  input  wire logic [15:0] ps_res_id,
  input  wire logic [31:0] ps_wdata,
  output logic             ps_ready,
  output logic             ps_done,
  output logic             ps_ok,
  output logic [31:0]      ps_rdata
);
  import cfm_pkg::*;

  // Whole engine state in one record
  typedef struct packed {
    cfm_state_e  st;       // Engine state
    logic [1:0]  cnt;      // Byte index within a field
    logic        is_wr;    // Message is a write
    logic        bad;      // Message seen malformed
    logic        ok;       // Reply is a success
    logic        narrow;   // One-byte read reply
    logic [23:0] rid;      // Return identifier
    logic [15:0] regn;     // Register number
    logic [31:0] wdata;    // Write data word
    logic [31:0] rdata;    // Read data being sent
    logic        ps_ok;    // Status access accepted
    logic        ps_done;  // Status access finished
    logic [31:0] ps_rdata; // Status read data
  } cfm_core_s;

  cfm_core_s         core_r;   // Registered state
  cfm_core_s         core_nxt; // Next state
  logic              rx_fire;  // Token taken
  logic              tx_fire;  // Token sent
  logic              mem_we;   // Bank write strobe
  logic [REG_AW-1:0] mem_addr; // Bank address
  logic [31:0]       mem_wdata;// Bank write data
  logic [31:0]       mem_rdata;// Bank read data
  logic [1:0]        last;     // Last index of current field
  logic              reg_ok;   // Register number is implemented

  cfm_regmem u_mem
  (
    .clock (clock),
    .arst_n(arst_n),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // Handshakes and stream outputs decoded from the state
  always_comb
  begin
    ps_ready = core_r.st == ST_IDLE;
    // Status port wins in idle so the bank has one user per cycle
    rx_ready = (core_r.st == ST_IDLE && !ps_valid) ||
               core_r.st == ST_RID  || core_r.st == ST_REG  ||
               core_r.st == ST_DATA || core_r.st == ST_END  ||
               core_r.st == ST_DROP;
    tx_valid = core_r.st == ST_ACK || core_r.st == ST_RDATA ||
               core_r.st == ST_CLOSE;
    tx_ctrl  = core_r.st != ST_RDATA;
    if (core_r.st == ST_ACK)
      tx_data = core_r.ok ? TOK_ACK : TOK_NAK;
    else if (core_r.st == ST_RDATA)
      tx_data = core_r.rdata[31:24];
    else
      tx_data = TOK_END;
    rx_fire  = rx_valid && rx_ready;
    tx_fire  = tx_valid && tx_ready;
    tx_dest  = core_r.rid;
    ps_done  = core_r.ps_done;
    ps_ok    = core_r.ps_ok;
    ps_rdata = core_r.ps_rdata;
  end

  // Field length for the byte collecting states
  always_comb
  begin
    if (core_r.st == ST_RID)
      last = RID_LAST;
    else if (core_r.st == ST_REG)
      last = REG_LAST;
    else
      last = DATA_LAST;
    reg_ok = core_r.regn < REG_NUM;
  end

  // Next-state logic of the message engine
  always_comb
  begin
    core_nxt         = core_r;
    core_nxt.ps_done = 1'b0;
    mem_we           = 1'b0;
    mem_addr         = core_r.regn[REG_AW-1:0];
    mem_wdata        = core_r.wdata;
    case (core_r.st)
      ST_IDLE:
      begin
        if (ps_valid)
        begin
          core_nxt.ps_ok = ps_res_id[7:0] == PS_TAG &&
                           {8'h00, ps_res_id[15:8]} < REG_NUM;
          mem_addr  = ps_res_id[PS_SHIFT +: REG_AW];
          mem_we    = ps_write && core_nxt.ps_ok;
          mem_wdata = ps_wdata;
          core_nxt.st = ST_PS;
        end
        else if (rx_fire)
        begin
          core_nxt.bad    = 1'b0;
          core_nxt.cnt    = 2'h0;
          core_nxt.narrow = narrow_access;
          if (rx_ctrl && rx_data == TOK_WRITE)
          begin
            core_nxt.is_wr = 1'b1;
            core_nxt.st    = ST_RID;
          end
          else if (rx_ctrl && rx_data == TOK_READ)
          begin
            core_nxt.is_wr = 1'b0;
            core_nxt.st    = ST_RID;
          end
          // A lone closing token is harmless
          else if (!(rx_ctrl && rx_data == TOK_END))
            core_nxt.st = ST_DROP;
        end
      end
      ST_PS:
      begin
        // Bank data for the status address arrives now
        core_nxt.ps_done  = 1'b1;
        core_nxt.ps_rdata = mem_rdata;
        core_nxt.st       = ST_IDLE;
      end
      ST_RID, ST_REG, ST_DATA:
      begin
        if (rx_fire && rx_ctrl)
        begin
          core_nxt.bad = 1'b1;
          // Without a full return id there is nowhere to answer
          if (core_r.st == ST_RID)
            core_nxt.st = rx_data == TOK_END ? ST_IDLE : ST_DROP;
          else
            core_nxt.st = rx_data == TOK_END ? ST_FIN : ST_END;
        end
        else if (rx_fire)
        begin
          if (core_r.st == ST_RID)
            core_nxt.rid = {core_r.rid[15:0], rx_data};
          else if (core_r.st == ST_REG)
            core_nxt.regn = {core_r.regn[7:0], rx_data};
          else
            core_nxt.wdata = {core_r.wdata[23:0], rx_data};
          core_nxt.cnt = core_r.cnt + 2'h1;
          if (core_r.cnt == last)
          begin
            core_nxt.cnt = 2'h0;
            if (core_r.st == ST_RID)
              core_nxt.st = ST_REG;
            else if (core_r.st == ST_REG && core_r.is_wr)
              core_nxt.st = ST_DATA;
            else
              core_nxt.st = ST_END;
          end
        end
      end
      ST_END:
      begin
        // extra bytes or tokens spoil it
        if (rx_fire && rx_ctrl && rx_data == TOK_END)
          core_nxt.st = ST_FIN;
        else if (rx_fire)
          core_nxt.bad = 1'b1;
      end
      ST_DROP:
      begin
        // Discard up to the closing token, no reply possible
        if (rx_fire && rx_ctrl && rx_data == TOK_END)
          core_nxt.st = ST_IDLE;
      end
      ST_FIN:
      begin
        core_nxt.ok = !core_r.bad && reg_ok;
        // narrow reply keeps the low byte
        core_nxt.rdata = core_r.narrow ? {mem_rdata[7:0], 24'h000000}
                                       : mem_rdata;
        if (core_r.is_wr)
        begin
          mem_we = core_nxt.ok;
          core_nxt.st = core_r.rid[7:0] == NO_REPLY_TAG ? ST_IDLE
                                                        : ST_ACK;
        end
        else
          core_nxt.st = ST_ACK;
      end
      ST_ACK:
      begin
        // data follows only a good read
        if (tx_fire)
        begin
          core_nxt.cnt = 2'h0;
          core_nxt.st  = (!core_r.is_wr && core_r.ok) ? ST_RDATA
                                                      : ST_CLOSE;
        end
      end
      ST_RDATA:
      begin
        if (tx_fire)
        begin
          core_nxt.rdata = {core_r.rdata[23:0], 8'h00};
          core_nxt.cnt   = core_r.cnt + 2'h1;
          if (core_r.narrow || core_r.cnt == DATA_LAST)
            core_nxt.st = ST_CLOSE;
        end
      end
      ST_CLOSE:
      begin
        if (tx_fire)
          core_nxt.st = ST_IDLE;
      end
      default:
        core_nxt.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      core_r <= '{st: ST_IDLE, default: '0};
    else
      core_r <= core_nxt;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  property p_silent_write;
    (core_r.st == ST_FIN && core_r.is_wr &&
     core_r.rid[7:0] == NO_REPLY_TAG) |=> !tx_valid [*2];
  endproperty
  a_silent_write: assert property (p_silent_write)
    else $error("reply sent for a no-reply write");

  property p_msb_first;
    (tx_fire && core_r.st == ST_RDATA && !core_r.narrow &&
     core_r.cnt != DATA_LAST) |=> tx_data == $past(core_r.rdata[23:16]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("read data bytes out of order");

  property p_ps_tag;
    (ps_valid && ps_ready && ps_res_id[7:0] != PS_TAG) |-> ##2
      (ps_done && !ps_ok);
  endproperty
  a_ps_tag: assert property (p_ps_tag)
    else $error("status id without tag accepted");

  property p_write_close;
    (tx_fire && core_r.st == ST_ACK && core_r.is_wr) |=>
      (tx_valid && tx_ctrl && tx_data == TOK_END);
  endproperty
  a_write_close: assert property (p_write_close)
    else $error("write reply not closed by token 1");

  property p_read_data;
    (tx_fire && core_r.st == ST_ACK && tx_data == TOK_ACK &&
     !core_r.is_wr) |=>
      (tx_valid && !tx_ctrl);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("good read reply lacks data");

  property p_narrow_one;
    (tx_fire && core_r.st == ST_RDATA && core_r.narrow) |=>
      (tx_ctrl && tx_data == TOK_END);
  endproperty
  a_narrow_one: assert property (p_narrow_one)
    else $error("narrow read sent more than one byte");

  property p_bad_keep;
    (core_r.st == ST_FIN && (core_r.bad || !reg_ok)) |->
      !mem_we ##1 (core_r.ok == 1'b0);
  endproperty
  a_bad_keep: assert property (p_bad_keep)
    else $error("bad request touched a register");

  property p_bad_nak;
    (core_r.st == ST_ACK && core_r.bad) |-> tx_data == TOK_NAK;
  endproperty
  a_bad_nak: assert property (p_bad_nak)
    else $error("bad request answered with success");

endmodule : cfm_endpoint

// *** testbench/cfm_requester.sv ***
// Requester model: sends token messages and gathers replies
`timescale 1ns/10ps
module cfm_requester
(
  // Clock
  input  wire logic       clock,
  // Request tokens toward the endpoint
  output logic            rx_valid,
  output logic            rx_ctrl,
  output logic [7:0]      rx_data,
  input  wire logic       rx_ready,
  // Reply tokens from the endpoint
  input  wire logic       tx_valid,
  input  wire logic       tx_ctrl,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [8:0] rxq[$];       // Replies as {ctrl, value}
  logic       slow = 1'b0;  // Stall replies every other cycle
  logic       hung = 1'b0;  // A token was never taken
  initial
  begin
    rx_valid = 1'b0;
    rx_ctrl  = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b1;
  end
  // Slow mode withholds ready to exercise reply holding
  always @(negedge clock)
    tx_ready <= slow ? ~tx_ready : 1'b1;
  // Collect each reply token on the edge it is taken
  always @(posedge clock)
    if (tx_valid && tx_ready)
      rxq.push_back({tx_ctrl, tx_data});
  // One token, held until the endpoint takes it
  task automatic put(input logic c, input logic [7:0] d);
    int n;
    @(negedge clock);
    rx_valid = 1'b1;
    rx_ctrl  = c;
    rx_data  = d;
    n = 0;
    do
      @(posedge clock);
    while (!rx_ready && ++n < 64);
    if (n == 64)
      hung = 1'b1;
  endtask : put
  // Released line shows the inverse, never a stale value
  task automatic idle();
    @(negedge clock);
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask : idle
  // Whole message; destination routing sits outside this model
  // message framing
  task automatic msg(input logic [7:0] hdr, input logic [23:0] rid,
                     input logic [15:0] regn, input logic [31:0] d);
    put(1'b1, hdr);
    for (int i = 2; i >= 0; i--)
      put(1'b0, rid[8*i+:8]);
    for (int i = 1; i >= 0; i--)
      put(1'b0, regn[8*i+:8]);
    // Only writes carry the data word
    if (hdr == 8'hc0)
      for (int i = 3; i >= 0; i--)
        put(1'b0, d[8*i+:8]);
    put(1'b1, 8'h01);
    idle();
  endtask : msg
endmodule : cfm_requester

// *** testbench/testbench.sv ***
// Self-checking bench for the configuration message endpoint
`timescale 1ns/10ps
module testbench;
  import cfm_pkg::*;
  logic        clock, arst_n, narrow_access;
  logic        rx_valid, rx_ctrl, rx_ready;
  logic [7:0]  rx_data, tx_data;
  logic        tx_valid, tx_ctrl, tx_ready;
  logic [23:0] tx_dest;
  logic        ps_valid, ps_write, ps_ready, ps_done, ps_ok;
  logic [15:0] ps_res_id;
  logic [31:0] ps_wdata, ps_rdata;
  int          error_cnt = 0;
  int          checked   = 0;
  localparam logic [8:0] A = 9'h103, N = 9'h104, E = 9'h101;

  cfm_endpoint cfm_endpoint_inst (.clock(clock), .arst_n(arst_n),
    .rx_valid(rx_valid), .rx_ctrl(rx_ctrl), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_ctrl(tx_ctrl),
    .tx_data(tx_data), .tx_ready(tx_ready), .tx_dest(tx_dest),
    .narrow_access(narrow_access), .ps_valid(ps_valid),
    .ps_write(ps_write), .ps_res_id(ps_res_id), .ps_wdata(ps_wdata),
    .ps_ready(ps_ready), .ps_done(ps_done), .ps_ok(ps_ok),
    .ps_rdata(ps_rdata));
  cfm_requester req_inst (.clock(clock), .rx_valid(rx_valid),
    .rx_ctrl(rx_ctrl), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_ctrl(tx_ctrl), .tx_data(tx_data),
    .tx_ready(tx_ready));

  // 25 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Wait for the expected reply tokens, then make sure no extra follow
  task automatic reply(input logic [8:0] e[$]);
    int i;
    for (i = 0; i < 80 && req_inst.rxq.size() < e.size(); i++)
      @(negedge clock);
    if (i == 80 || req_inst.hung)
    begin
      error_cnt++;
      tally_and_finish();
    end
    repeat (6) @(negedge clock);
    chk(req_inst.rxq.size(), e.size());
    foreach (e[k])
      if (k < req_inst.rxq.size())
        chk(req_inst.rxq[k], e[k]);
    req_inst.rxq.delete();
  endtask : reply

  // Full read reply for a word, MSB first
  task automatic rd(input logic [15:0] r, input logic [31:0] d);
    req_inst.msg(TOK_READ, 24'h0a0b0c, r, 32'h0);
    reply('{A, {1'b0, d[31:24]}, {1'b0, d[23:16]},
            {1'b0, d[15:8]}, {1'b0, d[7:0]}, E});
  endtask : rd

  // One status access; bounded waits for accept and completion
  task automatic ps_op(input logic w, input logic [15:0] id,
    input logic [31:0] wd, input logic ok, input logic [31:0] rdv);
    int n;
    @(negedge clock);
    ps_valid  = 1'b1;
    ps_write  = w;
    ps_res_id = id;
    ps_wdata  = wd;
    for (n = 0; n < 20 && !ps_ready; n++)
      @(negedge clock);
    // Never accepted: count it and stop
    if (n == 20)
    begin
      error_cnt++;
      tally_and_finish();
    end
    @(negedge clock);
    ps_valid  = 1'b0;
    ps_res_id = ~ps_res_id;
    ps_wdata  = ~ps_wdata;
    for (n = 0; n < 20 && !ps_done; n++)
      @(negedge clock);
    if (n == 20)
    begin
      error_cnt++;
      tally_and_finish();
    end
    chk(ps_ok, ok);
    if (!w)
      chk(ps_rdata, rdv);
  endtask : ps_op

  // Acknowledged write, return id latched, read back
  task automatic t_write_read();
    req_inst.msg(TOK_WRITE, 24'h123401, 16'h0002, 32'h81234567);
    reply('{A, E});
    chk(tx_dest, 24'h123401);
    rd(16'h0002, 32'h81234567);
  endtask : t_write_read

  // Write with all-ones low byte gets no reply but still lands
  task automatic t_silent();
    logic [8:0] none[$];
    req_inst.msg(TOK_WRITE, 24'h1234ff, 16'h0003, 32'ha5a50f0f);
    reply(none);
    rd(16'h0003, 32'ha5a50f0f);
  endtask : t_silent

  // Unknown register and truncated message fail, bank untouched
  task automatic t_fail();
    req_inst.msg(TOK_WRITE, 24'h000100, 16'h0010, 32'h0);
    reply('{N, E});
    req_inst.msg(TOK_READ, 24'h000100, 16'h0102, 32'h0);
    reply('{N, E});
    req_inst.put(1'b1, TOK_WRITE);
    for (int i = 0; i < 4; i++)
      req_inst.put(1'b0, 8'h00);
    req_inst.put(1'b1, TOK_END);
    req_inst.idle();
    reply('{N, E});
    rd(16'h0002, 32'h81234567);
  endtask : t_fail

  // Unknown header is dropped silently; an extra byte spoils a read
  task automatic t_drop();
    logic [8:0] none[$];
    req_inst.msg(8'hc5, 24'h000100, 16'h0002, 32'h0);
    reply(none);
    req_inst.put(1'b1, TOK_READ);
    for (int i = 0; i < 6; i++)
      req_inst.put(1'b0, (i == 3) ? 8'h00 : 8'h02);
    req_inst.put(1'b1, TOK_END);
    req_inst.idle();
    reply('{N, E});
  endtask : t_drop

  // Byte-wide read returns just the low byte
  task automatic t_narrow();
    narrow_access = 1'b1;
    req_inst.msg(TOK_READ, 24'h000200, 16'h0002, 32'h0);
    reply('{A, 9'h067, E});
    narrow_access = 1'b0;
  endtask : t_narrow

  // Partner stalls during a read reply
  task automatic t_stall();
    req_inst.slow = 1'b1;
    rd(16'h0003, 32'ha5a50f0f);
    req_inst.slow = 1'b0;
  endtask : t_stall

  // Status ids, shared bank, and a bad tag refused
  task automatic t_status();
    ps_op(1'b1, 16'h050b, 32'hcafe1234, 1'b1, 32'h0);
    rd(16'h0005, 32'hcafe1234);
    ps_op(1'b1, 16'h050a, 32'h0, 1'b0, 32'h0);
    ps_op(1'b0, 16'h050b, 32'h0, 1'b1, 32'hcafe1234);
    ps_op(1'b0, 16'h100b, 32'h0, 1'b0, 32'h0);
  endtask : t_status

  // Main sequence
  initial
  begin
    arst_n        = 1'b0;
    narrow_access = 1'b0;
    ps_valid      = 1'b0;
    ps_write      = 1'b0;
    ps_res_id     = 16'h0000;
    ps_wdata      = 32'h0;
    repeat (5) @(negedge clock);
    arst_n = 1'b1;
    t_write_read();
    t_silent();
    t_fail();
    t_drop();
    t_narrow();
    t_stall();
    t_status();
    tally_and_finish();
  end
endmodule : testbench
